/* uab_regs.svh */
// register offsets, field positions, reset values and rate constants of the
// autobaud / wake-on-break helper; included by both modules and the testbench
`ifndef UAB_REGS_SVH
`define UAB_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define UAB_OFS_RATE_CTRL 8'h00
`define UAB_OFS_DIV_LOW 8'h04
`define UAB_OFS_DIV_HIGH 8'h08
`define UAB_OFS_CONFIG 8'h0c
`define UAB_OFS_RX_DATA 8'h10
`define UAB_OFS_STATUS 8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UAB_BIT_AB_EN 0
`define UAB_BIT_WAKE_EN 1
`define UAB_BIT_WIDE_SEL 3
`define UAB_BIT_RX_IDLE 6
`define UAB_BIT_AB_OVF 7
`define UAB_BIT_HIGH_SPEED 0
`define UAB_BIT_SYNC_MODE 1
`define UAB_BIT_RX_FLAG 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define UAB_RST_DIV 16'h0000
`define UAB_RST_FLAGS 1'b0

// ----------------------------------------------------------------
// timing: base clock divides, calibration ratio, first count and last edge
// ----------------------------------------------------------------
`define UAB_BASE_DIV_SLOW 7'd64
`define UAB_BASE_DIV_MID 7'd16
`define UAB_BASE_DIV_FAST 7'd4
`define UAB_ABD_RATIO 4'd8
`define UAB_AB_FIRST_COUNT 16'h0001
`define UAB_AB_LAST_EDGE 3'd4

`endif

/* uab_pkg.sv */
// types shared by the autobaud / wake-on-break helper
// assumes uab_regs.svh is on the include path
package uab_pkg;
	typedef enum logic [1:0] {
		UAB_AB_IDLE = 2'b00,
		UAB_AB_START = 2'b01,
		UAB_AB_FIRST = 2'b10,
		UAB_AB_MEASURE = 2'b11
	} uab_ab_state_t;

	typedef struct packed {
		logic high_speed;
		logic wide_sel;
		logic sync_mode;
		logic calibrating;
		logic run;
	} uab_rate_cfg_t;
endpackage

/* uab_rate_gen.sv */
// rate generator: base prescale, calibration tick and bit-rate tick
// assumes one clock pclk; run low freezes every counter (clocks stopped)
`timescale 1ns/1ps
`include "uab_regs.svh"

module uab_rate_gen
	import uab_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire uab_rate_cfg_t cfg,
	input wire logic [15:0] divisor,
	output logic abd_tick,
	output logic rate_tick
);
	// ----------------------------------------------------------------
	// base clock select
	// ----------------------------------------------------------------
	function automatic logic [6:0] base_div(input logic wide, input logic hs);
		logic [6:0] d;
		d = `UAB_BASE_DIV_MID;
		if (!wide && !hs)
			d = `UAB_BASE_DIV_SLOW;
		else if (wide && hs)
			d = `UAB_BASE_DIV_FAST;
		return d;
	endfunction

	logic [6:0] pre_reg;
	logic [2:0] abd_reg;
	logic [15:0] bit_reg;
	wire [6:0] pre_last = base_div(cfg.wide_sel, cfg.high_speed) - 7'd1;
	wire base_tick = cfg.run && (pre_reg >= pre_last);
	wire [15:0] div_eff = cfg.wide_sel ? divisor : {8'h00, divisor[7:0]};
	wire abd_wrap = abd_reg == 3'(`UAB_ABD_RATIO - 4'd1);

	// the calibration tick is one eighth of the base tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_reg <= 7'd0;
			abd_reg <= 3'd0;
			bit_reg <= 16'h0000;
			abd_tick <= 1'b0;
			rate_tick <= 1'b0;
		end else begin
			abd_tick <= base_tick && abd_wrap && cfg.calibrating;
			rate_tick <= base_tick && !cfg.calibrating && (bit_reg == 16'h0000);
			if (cfg.run)
				pre_reg <= base_tick ? 7'd0 : pre_reg + 7'd1;
			if (!cfg.calibrating)
				abd_reg <= 3'd0;
			else if (base_tick)
				abd_reg <= abd_reg + 3'd1;
			if (base_tick)
				bit_reg <= (bit_reg == 16'h0000) ? div_eff : bit_reg - 16'h0001;
		end
	end

	property p_abd_needs_cal;
		@(posedge pclk) disable iff (!presetn)
		abd_tick |-> $past(cfg.calibrating && cfg.run);
	endproperty
	a_abd_needs_cal: assert property (p_abd_needs_cal) else $error("calibration tick outside calibration");
endmodule

/* uab_autobaud.sv */
// Functional notes
// - setting autobaud enable starts calibration, receiver idle
// - count from first rise after start bit
// - fifth rise: keep count, clear enable, set flag
// - reading receive data clears receive flag
// - both divisor bytes form one 16-bit counter
// - counter ticks at one eighth base rate
// - counter starts at one; software subtracts one
// - wake plus autobaud measures the following character
// - counter wrap before fifth rise sets overflow
// - after overflow keep counting to fifth rise
// - overflow cleared by software only when disabled
// - eight-bit modes: high byte zero means no overflow
// - sleep stops all serial unit clocks
// - wake enable suspends reception, watches falling edge
// - wake only in asynchronous mode
// - wake event sets receive flag
// - rise ending break clears wake enable
// - non-zero character: first low time is wake
//
// autobaud calibration and wake-on-break with an APB register slave
// assumes receive_line is synchronous to pclk and a receiver sits beside it
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "uab_regs.svh"

module uab_autobaud
	import uab_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic receive_line,
	input wire logic sleep_mode,
	input wire logic receiver_idle,
	input wire logic [7:0] rx_char,
	output logic receive_flag,
	output logic receive_suspend,
	output logic rate_tick
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	uab_ab_state_t state_reg;
	uab_ab_state_t state_next;
	logic ab_en_reg;
	logic wake_en_reg;
	logic ovf_reg;
	logic wide_sel_reg;
	logic high_speed_reg;
	logic sync_mode_reg;
	logic [15:0] div_reg;
	logic [2:0] edge_reg;
	logic line_prev_reg;
	logic [31:0] rdata_reg;
	logic err_reg;
	logic abd_tick;
	uab_rate_cfg_t rate_cfg;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	wire setup = psel && !penable;
	wire access = psel && penable;
	wire wr = access && pwrite;
	wire rd = access && !pwrite;
	wire hit_ctrl = paddr == `UAB_OFS_RATE_CTRL;
	wire hit_low = paddr == `UAB_OFS_DIV_LOW;
	wire hit_high = paddr == `UAB_OFS_DIV_HIGH;
	wire hit_cfg = paddr == `UAB_OFS_CONFIG;
	wire hit_data = paddr == `UAB_OFS_RX_DATA;
	wire hit_stat = paddr == `UAB_OFS_STATUS;
	wire mapped = hit_ctrl || hit_low || hit_high || hit_cfg || hit_data || hit_stat;
	wire wr_ctrl = wr && hit_ctrl;
	wire wr_cfg = wr && hit_cfg;
	wire rd_data = rd && hit_data;

	assign pready = 1'b1;
	assign pslverr = access && err_reg;
	assign prdata = rdata_reg;

	// ----------------------------------------------------------------
	// receive line edges
	// ----------------------------------------------------------------
	wire line_fall = line_prev_reg && !receive_line;
	wire line_rise = !line_prev_reg && receive_line;

	// ----------------------------------------------------------------
	// calibration sequencing
	// ----------------------------------------------------------------
	wire calibrating = state_reg != UAB_AB_IDLE;
	wire measuring = state_reg == UAB_AB_MEASURE;
	wire first_rise = (state_reg == UAB_AB_FIRST) && line_rise;
	wire fifth_rise = measuring && line_rise && (edge_reg == `UAB_AB_LAST_EDGE);
	wire cnt_wrap = measuring && abd_tick && (div_reg == 16'hffff);
	wire wake_active = wake_en_reg && !sync_mode_reg;
	wire wake_event = wake_active && line_fall;
	wire wake_done = wake_active && line_rise;
	wire flag_set = fifth_rise || wake_event;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			UAB_AB_IDLE: begin
				// a pending wake holds calibration back for the next character
				if (ab_en_reg && !wake_en_reg)
					state_next = UAB_AB_START;
			end
			UAB_AB_START: begin
				if (line_fall)
					state_next = UAB_AB_FIRST;
			end
			UAB_AB_FIRST: begin
				if (line_rise)
					state_next = UAB_AB_MEASURE;
			end
			UAB_AB_MEASURE: begin
				if (fifth_rise)
					state_next = UAB_AB_IDLE;
			end
		endcase
		// software abort: clearing the enable drops the sequence at once
		if (!ab_en_reg)
			state_next = UAB_AB_IDLE;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_reg <= UAB_AB_IDLE;
		else
			state_reg <= state_next;
	end

	// the receiver stays idle while measuring or waiting for a wake
	assign receive_suspend = calibrating || ab_en_reg || wake_active;

	// ----------------------------------------------------------------
	// rising edge count and divisor pair
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			edge_reg <= 3'd0;
		else if (first_rise)
			edge_reg <= 3'd1;
		else if (measuring && line_rise)
			edge_reg <= edge_reg + 3'd1;
	end

	// during calibration both bytes count as one word, whatever the width select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg <= `UAB_RST_DIV;
		end else if (first_rise) begin
			div_reg <= `UAB_AB_FIRST_COUNT;
		end else if (measuring) begin
			if (abd_tick)
				div_reg <= div_reg + 16'h0001;
		end else if (!calibrating && wr && hit_low) begin
			div_reg[7:0] <= pwdata[7:0];
		end else if (!calibrating && wr && hit_high) begin
			div_reg[15:8] <= pwdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// control bits and flags
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ab_en_reg <= 1'b0;
			wake_en_reg <= 1'b0;
			wide_sel_reg <= 1'b0;
		end else begin
			if (wr_ctrl)
				wide_sel_reg <= pwdata[`UAB_BIT_WIDE_SEL];
			// hardware completion wins over a software write in the same cycle
			if (fifth_rise)
				ab_en_reg <= 1'b0;
			else if (wr_ctrl)
				ab_en_reg <= pwdata[`UAB_BIT_AB_EN];
			if (wake_done)
				wake_en_reg <= 1'b0;
			else if (wr_ctrl)
				wake_en_reg <= pwdata[`UAB_BIT_WAKE_EN];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_speed_reg <= 1'b0;
			sync_mode_reg <= 1'b0;
		end else if (wr_cfg) begin
			high_speed_reg <= pwdata[`UAB_BIT_HIGH_SPEED];
			sync_mode_reg <= pwdata[`UAB_BIT_SYNC_MODE];
		end
	end

	// overflow: set wins; a written zero only lands while the enable is clear
	wire ovf_clear = wr_ctrl && !pwdata[`UAB_BIT_AB_OVF] && !ab_en_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ovf_reg <= `UAB_RST_FLAGS;
		else if (cnt_wrap)
			ovf_reg <= 1'b1;
		else if (ovf_clear)
			ovf_reg <= 1'b0;
	end

	// receive flag: a set in the cycle of the clearing read wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			receive_flag <= `UAB_RST_FLAGS;
		else if (flag_set)
			receive_flag <= 1'b1;
		else if (rd_data)
			receive_flag <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			line_prev_reg <= 1'b1;
		else
			line_prev_reg <= receive_line;
	end

	// ----------------------------------------------------------------
	// read data, captured in the setup phase
	// ----------------------------------------------------------------
	wire [7:0] ctrl_view = {ovf_reg, receiver_idle, 2'b00, wide_sel_reg, 1'b0,
		wake_en_reg, ab_en_reg};
	wire [7:0] rd_byte = hit_ctrl ? ctrl_view :
		hit_low ? div_reg[7:0] :
		hit_high ? div_reg[15:8] :
		hit_cfg ? {6'h00, sync_mode_reg, high_speed_reg} :
		hit_data ? rx_char :
		hit_stat ? {7'h00, receive_flag} : 8'h00;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg <= 32'h0000_0000;
			err_reg <= 1'b0;
		end else if (setup) begin
			rdata_reg <= {24'h00_0000, rd_byte};
			err_reg <= !mapped;
		end
	end

	// ----------------------------------------------------------------
	// rate generator; sleep freezes it
	// ----------------------------------------------------------------
	assign rate_cfg = '{high_speed: high_speed_reg, wide_sel: wide_sel_reg,
		sync_mode: sync_mode_reg, calibrating: measuring, run: !sleep_mode};

	uab_rate_gen u_rate (
		.pclk(pclk),
		.presetn(presetn),
		.cfg(rate_cfg),
		.divisor(div_reg),
		.abd_tick(abd_tick),
		.rate_tick(rate_tick)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_last_rise;
		measuring && line_rise && edge_reg == 3'd4;
	endsequence
	sequence s_done;
		!ab_en_reg && receive_flag && state_reg == UAB_AB_IDLE;
	endsequence

	// an armed enable with no wake pending must leave idle and hold the receiver off
	property p_cal_suspends;
		(ab_en_reg && !wake_en_reg && state_reg == UAB_AB_IDLE) |=>
			(state_reg == UAB_AB_START && receive_suspend);
	endproperty
	a_cal_suspends: assert property (p_cal_suspends) else $error("receiver not idle during calibration");

	property p_first_count;
		(state_reg == UAB_AB_FIRST && line_rise && !wr_ctrl && ab_en_reg) |=> div_reg == 16'h0001;
	endproperty
	a_first_count: assert property (p_first_count) else $error("counter did not start at one");

	property p_fifth_done;
		s_last_rise |=> s_done;
	endproperty
	a_fifth_done: assert property (p_fifth_done) else $error("fifth rise did not finish calibration");

	property p_read_clears;
		(rd_data && !flag_set) |=> !receive_flag;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("data read left receive flag set");

	property p_count_step;
		(measuring && abd_tick && !fifth_rise && ab_en_reg) |=> div_reg == $past(div_reg) + 16'h0001;
	endproperty
	a_count_step: assert property (p_count_step) else $error("divisor pair did not step");

	property p_overflow_sets;
		cnt_wrap |=> ovf_reg && div_reg == 16'h0000;
	endproperty
	a_overflow_sets: assert property (p_overflow_sets) else $error("wrap did not set overflow");

	property p_ovf_sticky;
		(ovf_reg && ab_en_reg) |=> ovf_reg;
	endproperty
	a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow cleared while enabled");

	property p_wake_flag;
		wake_event |=> receive_flag;
	endproperty
	a_wake_flag: assert property (p_wake_flag) else $error("wake event missed receive flag");

	property p_wake_clear;
		wake_done |=> !wake_en_reg;
	endproperty
	a_wake_clear: assert property (p_wake_clear) else $error("break end did not clear wake enable");

	property p_wake_defers;
		(wake_en_reg && state_reg == UAB_AB_IDLE) |=> state_reg == UAB_AB_IDLE;
	endproperty
	a_wake_defers: assert property (p_wake_defers) else $error("calibration began during wake");

	property p_sync_no_wake;
		(sync_mode_reg && wake_en_reg && line_rise && !wr_ctrl) |=> wake_en_reg;
	endproperty
	a_sync_no_wake: assert property (p_sync_no_wake) else $error("wake acted in synchronous mode");
endmodule

/* uab_line_model.sv */
// remote serial transmitter that drives the receive line of the helper
// assumes the bench calls one task at a time; line idles high between frames
`timescale 1ns/1ps

module uab_line_model (
	output logic line,
	input wire logic pclk
);
	initial begin
		line = 1'b1;
	end

	// ----------------------------------------------------------------
	// framing
	// ----------------------------------------------------------------
	// level changes just after an edge and lasts the given cycles
	task automatic hold(input logic level, input int cycles);
		@(posedge pclk);
		line <= level;
		repeat (cycles - 1) @(posedge pclk);
	endtask

	task automatic send_char(input logic [7:0] data, input int bitlen);
		hold(1'b0, bitlen);
		for (int i = 0; i < 8; i++) begin
			hold(data[i], bitlen);
		end
		hold(1'b1, bitlen);
	endtask

	// all-zero wake character, then idle time for the far end to start up
	task automatic send_break(input int bits, input int bitlen);
		hold(1'b0, bits * bitlen);
		hold(1'b1, 4 * bitlen);
	endtask
endmodule

/* testbench.sv */
// self-checking bench for the autobaud / wake-on-break helper
// assumes uab_regs.svh on the include path and a zero-wait apb slave
`timescale 1ns/1ps
`include "uab_regs.svh"

module testbench;
	logic pclk, presetn, psel, penable, pwrite, sleep_mode, receiver_idle;
	logic [7:0] paddr, rx_char;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, receive_flag, receive_suspend, rate_tick, receive_line, err;
	int fail_count, compares;

	uab_autobaud DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .receive_line(receive_line), .sleep_mode(sleep_mode),
		.receiver_idle(receiver_idle), .rx_char(rx_char), .receive_flag(receive_flag),
		.receive_suspend(receive_suspend), .rate_tick(rate_tick));

	uab_line_model PARTNER (.line(receive_line), .pclk(pclk));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	// request held until the edge that samples pready high
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) chk("pready", 32'h1, 32'h0);
	endtask

	task automatic rdchk(input string name, input logic [7:0] addr, input logic [31:0] exp);
		apb(1'b0, addr, 32'h0);
		chk(name, exp, rd);
	endtask

	task automatic flag_is(input logic exp);
		int n;
		n = 0;
		while (receive_flag !== exp && n < 20) begin
			@(posedge pclk);
			n++;
		end
		chk("receive_flag", 32'(exp), 32'(receive_flag));
	endtask

	// divisor pair after calibration; prescaler phase allows one tick less
	task automatic div_is(input int ticks, input logic wide);
		logic [15:0] div;
		apb(1'b0, `UAB_OFS_DIV_LOW, 32'h0);
		div[7:0] = rd[7:0];
		apb(1'b0, `UAB_OFS_DIV_HIGH, 32'h0);
		div[15:8] = rd[7:0];
		compares++;
		if (div !== 16'(ticks + 1) && div !== 16'(ticks)) begin
			fail_count++;
			$display("BAD divisor expected %0d seen %h", ticks + 1, div);
		end
		if (!wide) chk("divisor_high", 32'h0, 32'(div[15:8]));
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rdchk("rate_control", `UAB_OFS_RATE_CTRL, 32'h40);
		rdchk("divisor_low", `UAB_OFS_DIV_LOW, 32'h0);
		rdchk("divisor_high", `UAB_OFS_DIV_HIGH, 32'h0);
		rdchk("unmapped", 8'h1c, 32'h0);
		chk("pslverr", 32'h1, 32'(err));
		$display("test reset done");
	endtask

	// 55h at 64 cycles a bit: eight bits between first and fifth rise
	task automatic t_autobaud();
		logic hs, wide;
		int p;
		for (int m = 0; m < 4; m++) begin
			hs = m[0];
			wide = m[1];
			p = (m == 0) ? 512 : (m == 3) ? 32 : 128;
			apb(1'b1, `UAB_OFS_CONFIG, 32'(hs));
			apb(1'b1, `UAB_OFS_RATE_CTRL, 32'(wide) << 3 | 32'h1);
			@(posedge pclk);
			chk("suspend", 32'h1, 32'(receive_suspend));
			PARTNER.send_char(8'h55, 64);
			flag_is(1'b1);
			chk("suspend", 32'h0, 32'(receive_suspend));
			rdchk("rate_control", `UAB_OFS_RATE_CTRL, 32'h40 | 32'(wide) << 3);
			div_is(512 / p, wide);
			rdchk("rx_data", `UAB_OFS_RX_DATA, 32'(rx_char));
			flag_is(1'b0);
		end
		$display("test autobaud done");
	endtask

	task automatic t_abort();
		apb(1'b1, `UAB_OFS_RATE_CTRL, 32'h1);
		apb(1'b1, `UAB_OFS_RATE_CTRL, 32'h0);
		// the sequencer drops to idle one edge after the enable clears
		repeat (2) @(posedge pclk);
		chk("suspend", 32'h0, 32'(receive_suspend));
		rdchk("rate_control", `UAB_OFS_RATE_CTRL, 32'h40);
		PARTNER.send_char(8'h55, 16);
		chk("receive_flag", 32'h0, 32'(receive_flag));
		$display("test abort done");
	endtask

	task automatic t_wake();
		apb(1'b1, `UAB_OFS_CONFIG, 32'h2);
		apb(1'b1, `UAB_OFS_RATE_CTRL, 32'h2);
		PARTNER.send_break(13, 16);
		chk("receive_flag", 32'h0, 32'(receive_flag));
		apb(1'b1, `UAB_OFS_CONFIG, 32'h0);
		apb(1'b1, `UAB_OFS_RATE_CTRL, 32'h2);
		PARTNER.send_char(8'h55, 16);
		flag_is(1'b1);
		rdchk("rate_control", `UAB_OFS_RATE_CTRL, 32'h40);
		rdchk("rx_data", `UAB_OFS_RX_DATA, 32'(rx_char));
		// software looks at the idle flag before arming the wake
		receiver_idle <= 1'b0;
		rdchk("rx_idle_busy", `UAB_OFS_RATE_CTRL, 32'h00);
		receiver_idle <= 1'b1;
		rdchk("rx_idle_free", `UAB_OFS_RATE_CTRL, 32'h40);
		apb(1'b1, `UAB_OFS_CONFIG, 32'h1);
		sleep_mode <= 1'b1;
		apb(1'b1, `UAB_OFS_RATE_CTRL, 32'h0b);
		@(posedge pclk);
		chk("suspend", 32'h1, 32'(receive_suspend));
		PARTNER.send_break(13, 64);
		flag_is(1'b1);
		rdchk("rate_control", `UAB_OFS_RATE_CTRL, 32'h49);
		rdchk("rx_data", `UAB_OFS_RX_DATA, 32'(rx_char));
		flag_is(1'b0);
		sleep_mode <= 1'b0;
		PARTNER.send_char(8'h55, 64);
		flag_is(1'b1);
		div_is(16, 1'b1);
		rdchk("rx_data", `UAB_OFS_RX_DATA, 32'(rx_char));
		$display("test wake done");
	endtask

	// both speed selects, divisor 3: a bit lasts 4 * (3 + 1) clocks
	task automatic t_rate();
		int n;
		apb(1'b1, `UAB_OFS_CONFIG, 32'h1);
		apb(1'b1, `UAB_OFS_RATE_CTRL, 32'h8);
		apb(1'b1, `UAB_OFS_DIV_LOW, 32'h3);
		apb(1'b1, `UAB_OFS_DIV_HIGH, 32'h0);
		n = 0;
		while (rate_tick !== 1'b1 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (rate_tick !== 1'b1 && n < 100);
		chk("bit_period", 32'd16, 32'(n));
		$display("test rate done");
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		sleep_mode = 1'b0;
		receiver_idle = 1'b1;
		rx_char = 8'ha5;
		presetn = 1'b0;
		fail_count = 0;
		compares = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_autobaud();
		t_abort();
		t_wake();
		t_rate();
		end_sim();
	end

	// the tests need about 5000 clocks
	initial begin
		repeat (40000) @(posedge pclk);
		fail_count++;
		$display("BAD watchdog expected finish seen hang");
		end_sim();
	end
endmodule
